/* File: logic/cit_pkg.sv */
package cit_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_H_TOTAL       = 6'h00;
    localparam logic [5:0] IDX_H_DISP        = 6'h01;
    localparam logic [5:0] IDX_H_SYNC_POS    = 6'h02;
    localparam logic [5:0] IDX_SYNC_WIDTH    = 6'h03;
    localparam logic [5:0] IDX_V_TOTAL       = 6'h04;
    localparam logic [5:0] IDX_V_ADJUST      = 6'h05;
    localparam logic [5:0] IDX_V_DISP        = 6'h06;
    localparam logic [5:0] IDX_V_SYNC_POS    = 6'h07;
    localparam logic [5:0] IDX_MODE_CONTROL  = 6'h08;
    localparam logic [5:0] IDX_LINES_PER_ROW = 6'h09;
    localparam logic [5:0] IDX_CURSOR_FIRST  = 6'h0a;
    localparam logic [5:0] IDX_CURSOR_LAST   = 6'h0b;
    localparam logic [5:0] IDX_START_HIGH    = 6'h0c;
    localparam logic [5:0] IDX_START_LOW     = 6'h0d;
    localparam logic [5:0] IDX_CURSOR_HIGH   = 6'h0e;
    localparam logic [5:0] IDX_CURSOR_LOW    = 6'h0f;
    localparam logic [5:0] IDX_PEN_HIGH      = 6'h10;
    localparam logic [5:0] IDX_PEN_LOW       = 6'h11;
    localparam logic [5:0] IDX_UPDATE_HIGH   = 6'h12;
    localparam logic [5:0] IDX_UPDATE_LOW    = 6'h13;
    localparam logic [5:0] IDX_UPDATE_TRIG   = 6'h1f;
    localparam logic [5:0] IDX_STATUS        = 6'h20;

    // Mode control field positions
    localparam int MODE_INTERLACE = 0;
    localparam int MODE_VIDEO     = 1;
    localparam int MODE_ROWCOL    = 2;
    localparam int MODE_TRANSP    = 3;
    localparam int MODE_DE_SKEW   = 4;
    localparam int MODE_CUR_SKEW  = 5;

    // Status field positions
    localparam int STAT_FIELD     = 0;
    localparam int STAT_VBLANK    = 5;
    localparam int STAT_PEN_FULL  = 6;
    localparam int STAT_UPD_READY = 7;

    // Value after reset of every register, and sync width for a zero
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [4:0] WIDTH_ZERO = 5'h10;

    // Vertical sequencer states
    typedef enum logic [1:0] {
        V_ROWS = 2'b01,
        V_ADJ  = 2'b10
    } cit_vstate_t;

    // Register bank, twenty bytes
    typedef logic [19:0][7:0] cit_regs_t;

    // Signals toward display memory and monitor
    typedef struct packed {
        logic [13:0] ma;
        logic [4:0]  ra;
        logic        de;
        logic        cursor;
        logic        hsync;
        logic        vsync;
        logic        updStb;
    } cit_video_t;

    // Whole state of the controller
    typedef struct packed {
        cit_regs_t   regs;
        logic [7:0]  hcnt;
        logic [4:0]  ra;
        logic [6:0]  row;
        logic [4:0]  adj;
        cit_vstate_t vst;
        logic        field;
        logic [13:0] rowBase;
        logic [4:0]  hsCnt;
        logic [4:0]  vsCnt;
        logic        deDly;
        logic        curDly;
        logic        penPrev;
        logic        penFull;
        logic        updPend;
        logic        updReady;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        cit_video_t  vid;
    } cit_state_t;

endpackage

/* File: logic/cit_crt_timing.sv */
`timescale 1ns/1ps

// What this block does
// - Non-interlaced: one field is one frame
// - Interlaced modes alternate even and odd fields
// - Interlace sync delays vsync half line, odd
// - Sync plus video: even lines even fields
// - Sync plus video: delayed vsync, altered addressing
// - Mode bit 4 skews enable, bit 5 cursor
// - Mode bits 0 and 1 pick scan mode
// - Mode bit 2 picks address register format
// - Zero binary; one row high, column low
// - Mode bit 3 picks shared or transparent
// - Cursor skew delays cursor one character tick
// - Sync width holds horizontal and vertical widths
// - Update pair and trigger only when transparent
// - Cursor line limits may be odd or even
module cit_crt_timing (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output      logic [31:0]        prdata,
    output      logic               pready,
    output      logic               pslverr,
    input  wire logic               lightPenIn,
    output      cit_pkg::cit_video_t video
);

    // Registered state and its next value
    cit_pkg::cit_state_t s_q;
    cit_pkg::cit_state_t s_d;

    // Decoded mode and derived timing terms
    logic [7:0]  mode;       // Mode control byte
    logic        ilv;        // Any interlaced mode
    logic        sv;         // Interlace sync plus video
    logic [7:0]  half;       // Half a scan line in ticks
    logic [7:0]  vPoint;     // Tick on which vsync moves
    logic        hEnd;       // Last tick of a line
    logic        rowEnd;     // Last shown line of a row
    logic        lastRow;    // Row equals vertical total
    logic        frameEnd;   // Last tick of the field
    logic        newField;   // Field after this one
    logic [4:0]  raFirst;    // First line of a row
    logic        deRaw;      // Display window before skew
    logic        curHit;     // Cursor before skew
    logic        strobeNow;  // Update slot taken now
    logic [13:0] maRaw;      // Refresh address
    logic [13:0] startAddr;  // Display start
    logic [13:0] curAddr;    // Cursor position
    logic [13:0] updAddr;    // Update address pair
    logic [13:0] updNext;    // Update address plus one
    logic [5:0]  idx;        // Register index from paddr
    logic        hit;        // Index is mapped
    logic        acc;        // Access phase completes
    logic        vblank;     // Outside the displayed rows
    logic [7:0]  rdByte;     // Read data for the index

    // Joins a high and a low byte into a 14-bit address
    function automatic logic [13:0] pair14(
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        pair14 = {hi[5:0], lo};
    endfunction

    // Sync width field; zero stands for sixteen
    function automatic logic [4:0] syncLen(input logic [3:0] w);
        syncLen = (w == 4'h0) ? cit_pkg::WIDTH_ZERO : {1'b0, w};
    endfunction

    // Registers that software may write
    function automatic logic writable(input logic [5:0] i);
        writable = (i <= cit_pkg::IDX_UPDATE_LOW)
                && (i != cit_pkg::IDX_PEN_HIGH)
                && (i != cit_pkg::IDX_PEN_LOW);
    endfunction

    // Outputs come straight from the state flops
    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign video   = s_q.vid;

    // Next-state logic for the whole controller
    always_comb begin
        s_d = s_q;
        mode = s_q.regs[cit_pkg::IDX_MODE_CONTROL];
        // Bit 0 interlaces, bit 1 adds video interlace
        ilv = mode[cit_pkg::MODE_INTERLACE];
        sv = ilv && mode[cit_pkg::MODE_VIDEO];
        startAddr = pair14(s_q.regs[cit_pkg::IDX_START_HIGH],
                           s_q.regs[cit_pkg::IDX_START_LOW]);
        curAddr = pair14(s_q.regs[cit_pkg::IDX_CURSOR_HIGH],
                         s_q.regs[cit_pkg::IDX_CURSOR_LOW]);
        updAddr = pair14(s_q.regs[cit_pkg::IDX_UPDATE_HIGH],
                         s_q.regs[cit_pkg::IDX_UPDATE_LOW]);
        updNext = updAddr + 14'h0001;
        half = 8'((9'(s_q.regs[cit_pkg::IDX_H_TOTAL]) + 9'h001) >> 1);
        // Odd interlaced fields move vsync by half a line
        vPoint = (ilv && s_q.field) ? half : 8'h00;
        hEnd = (s_q.hcnt == s_q.regs[cit_pkg::IDX_H_TOTAL]);
        // Video interlace steps lines by two from the field
        raFirst = sv ? {4'h0, s_q.field} : 5'h00;
        rowEnd = (6'(s_q.ra) + (sv ? 6'h02 : 6'h01))
               > {1'b0, s_q.regs[cit_pkg::IDX_LINES_PER_ROW][4:0]};
        lastRow = (s_q.row == s_q.regs[cit_pkg::IDX_V_TOTAL][6:0]);
        // Frame ends on last row, or after the adjust lines
        frameEnd = hEnd && (
            (s_q.vst == cit_pkg::V_ROWS && rowEnd && lastRow
             && s_q.regs[cit_pkg::IDX_V_ADJUST][4:0] == 5'h00)
            || (s_q.vst == cit_pkg::V_ADJ
             && 5'(s_q.adj + 5'h01)
                == s_q.regs[cit_pkg::IDX_V_ADJUST][4:0]));
        // Non-interlaced keeps field zero: field equals frame
        newField = ilv && !s_q.field;
        vblank = (s_q.vst == cit_pkg::V_ADJ)
              || (s_q.row >= s_q.regs[cit_pkg::IDX_V_DISP][6:0]);
        deRaw = !vblank
             && (s_q.hcnt < s_q.regs[cit_pkg::IDX_H_DISP]);
        // Row/column forms {row, column}; binary runs linear
        if (mode[cit_pkg::MODE_ROWCOL]) begin
            maRaw = {s_q.row[5:0], s_q.hcnt} + startAddr;
        end else begin
            maRaw = s_q.rowBase + {6'h00, s_q.hcnt};
        end
        // Any line limits match, odd or even
        curHit = deRaw && (maRaw == curAddr)
              && (s_q.ra >= s_q.regs[cit_pkg::IDX_CURSOR_FIRST][4:0])
              && (s_q.ra <= s_q.regs[cit_pkg::IDX_CURSOR_LAST][4:0]);

        // Character counter
        s_d.hcnt = hEnd ? 8'h00 : 8'(s_q.hcnt + 8'h01);

        // Line, row and adjust sequencing at end of line
        if (hEnd) begin
            case (s_q.vst)
                cit_pkg::V_ROWS: begin
                    if (rowEnd) begin
                        s_d.ra = raFirst;
                        s_d.rowBase = s_q.rowBase + 14'(
                            s_q.regs[cit_pkg::IDX_H_DISP]);
                        s_d.row = 7'(s_q.row + 7'h01);
                        if (lastRow) begin
                            s_d.vst = cit_pkg::V_ADJ;
                            s_d.adj = 5'h00;
                        end
                    end else begin
                        // Two lines a step when video interlaces
                        s_d.ra = 5'(s_q.ra + (sv ? 5'h02 : 5'h01));
                    end
                end
                cit_pkg::V_ADJ: begin
                    // Extra scan lines after the last row
                    s_d.adj = 5'(s_q.adj + 5'h01);
                end
                default: begin
                    // Lost one-hot code: back to the row state
                    s_d.vst = cit_pkg::V_ROWS;
                end
            endcase
            if (frameEnd) begin
                s_d.vst = cit_pkg::V_ROWS;
                s_d.row = 7'h00;
                s_d.field = newField;
                s_d.ra = sv ? {4'h0, newField} : 5'h00;
                s_d.rowBase = startAddr;
            end
        end

        // Horizontal sync, low nibble of sync width
        if (s_q.hsCnt != 5'h00) begin
            s_d.hsCnt = 5'(s_q.hsCnt - 5'h01);
        end
        if (s_q.hcnt == s_q.regs[cit_pkg::IDX_H_SYNC_POS]) begin
            s_d.hsCnt = syncLen(
                s_q.regs[cit_pkg::IDX_SYNC_WIDTH][3:0]);
        end

        // Vertical sync counts lines, high nibble of width
        if (s_q.hcnt == vPoint) begin
            if (s_q.vsCnt != 5'h00) begin
                s_d.vsCnt = 5'(s_q.vsCnt - 5'h01);
            end else if (s_q.vst == cit_pkg::V_ROWS
                    && s_q.row == s_q.regs[cit_pkg::IDX_V_SYNC_POS][6:0]
                    && s_q.ra == raFirst) begin
                s_d.vsCnt = syncLen(
                    s_q.regs[cit_pkg::IDX_SYNC_WIDTH][7:4]);
            end
        end

        // Video outputs; skew adds one tick of delay
        s_d.deDly = deRaw;
        s_d.curDly = curHit;
        s_d.vid.de = mode[cit_pkg::MODE_DE_SKEW]
                   ? s_q.deDly : deRaw;
        s_d.vid.cursor = mode[cit_pkg::MODE_CUR_SKEW]
                       ? s_q.curDly : curHit;
        s_d.vid.hsync = (s_d.hsCnt != 5'h00);
        s_d.vid.vsync = (s_d.vsCnt != 5'h00);
        s_d.vid.ra = s_q.ra;
        s_d.vid.ma = maRaw;
        s_d.vid.updStb = 1'b0;

        // Transparent update slot: only while blanked
        strobeNow = mode[cit_pkg::MODE_TRANSP]
                 && s_q.updPend && !deRaw;
        if (strobeNow) begin
            s_d.vid.ma = updAddr;
            s_d.vid.updStb = 1'b1;
            s_d.updPend = 1'b0;
            s_d.updReady = 1'b1;
            s_d.regs[cit_pkg::IDX_UPDATE_HIGH] = {2'b00, updNext[13:8]};
            s_d.regs[cit_pkg::IDX_UPDATE_LOW] = updNext[7:0];
        end

        // Register read data, write-only ones read zero
        idx = paddr[7:2];
        hit = (paddr[1:0] == 2'b00)
           && (idx <= cit_pkg::IDX_UPDATE_LOW
               || idx == cit_pkg::IDX_UPDATE_TRIG
               || idx == cit_pkg::IDX_STATUS);
        case (idx)
            cit_pkg::IDX_MODE_CONTROL,
            cit_pkg::IDX_CURSOR_HIGH, cit_pkg::IDX_CURSOR_LOW,
            cit_pkg::IDX_PEN_HIGH, cit_pkg::IDX_PEN_LOW,
            cit_pkg::IDX_UPDATE_HIGH, cit_pkg::IDX_UPDATE_LOW: begin
                rdByte = s_q.regs[idx[4:0]];
            end
            cit_pkg::IDX_STATUS: begin
                rdByte = 8'h00;
                rdByte[cit_pkg::STAT_FIELD] = s_q.field;
                rdByte[cit_pkg::STAT_VBLANK] = vblank;
                rdByte[cit_pkg::STAT_PEN_FULL] = s_q.penFull;
                rdByte[cit_pkg::STAT_UPD_READY] = s_q.updReady;
            end
            default: begin
                rdByte = 8'h00;
            end
        endcase

        // APB slave: answer one cycle after setup
        s_d.pready = psel && !penable;
        s_d.pslverr = psel && !penable && !hit;
        if (psel && !penable) begin
            s_d.prdata = {24'h000000, rdByte};
        end
        acc = psel && penable && s_q.pready && !s_q.pslverr;
        if (acc && pwrite && writable(idx)) begin
            // Software write beats a same-tick increment
            s_d.regs[idx[4:0]] = pwdata[7:0];
        end
        // Trigger touch only counts when transparent
        if (acc && idx == cit_pkg::IDX_UPDATE_TRIG
            && mode[cit_pkg::MODE_TRANSP]) begin
            s_d.updPend = 1'b1;
            if (!strobeNow) begin
                s_d.updReady = 1'b0;
            end
        end
        if (acc && !pwrite && (idx == cit_pkg::IDX_PEN_HIGH
                            || idx == cit_pkg::IDX_PEN_LOW)) begin
            s_d.penFull = 1'b0;
        end

        // Light pen rising edge captures the address; set wins
        s_d.penPrev = lightPenIn;
        if (lightPenIn && !s_q.penPrev) begin
            s_d.regs[cit_pkg::IDX_PEN_HIGH] = {2'b00, maRaw[13:8]};
            s_d.regs[cit_pkg::IDX_PEN_LOW] = maRaw[7:0];
            s_d.penFull = 1'b1;
        end
    end

    // State register; the sequencer restarts in its row state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.vst <= cit_pkg::V_ROWS;
        end else begin
            s_q <= s_d;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // A frame boundary in each kind of mode
    sequence frameIlv;
        frameEnd && ilv;
    endsequence
    sequence frameFlat;
        frameEnd && !ilv;
    endsequence

    chk_hcnt_wrap: assert property (
        hEnd |=> s_q.hcnt == 8'h00)
        else $error("character counter did not wrap");

    chk_field_flat: assert property (
        frameFlat |=> !s_q.field)
        else $error("field moved in non-interlaced mode");

    chk_field_alt: assert property (
        frameIlv |=> s_q.field != $past(s_q.field))
        else $error("interlaced field did not alternate");

    chk_vsync_half: assert property (
        $rose(video.vsync) |-> $past(s_q.hcnt) == $past(vPoint))
        else $error("vsync began off its field point");

    chk_video_lines: assert property (
        frameEnd && sv |=> s_q.ra[0] == s_q.field)
        else $error("row line does not match field parity");

    chk_line_step: assert property (
        hEnd && sv && !rowEnd && s_q.vst == cit_pkg::V_ROWS
        |=> s_q.ra == $past(s_q.ra) + 5'h02)
        else $error("video interlace line step not two");

    chk_de_skew: assert property (
        mode[cit_pkg::MODE_DE_SKEW] && $past(s_q.regs[8][4])
        |=> video.de == $past(deRaw, 2))
        else $error("skewed enable not delayed");

    chk_cursor_skew: assert property (
        mode[cit_pkg::MODE_CUR_SKEW] && $past(s_q.regs[8][5])
        |=> video.cursor == $past(curHit, 2))
        else $error("skewed cursor not delayed");

    chk_hsync_width: assert property (
        $rose(video.hsync) && $past(s_q.regs[3][3:0]) == 4'h8
        |-> video.hsync [*8] ##1 !video.hsync)
        else $error("horizontal sync width wrong");

    chk_update_shared: assert property (
        !$past(mode[cit_pkg::MODE_TRANSP]) |-> !video.updStb)
        else $error("update strobe in shared mode");

endmodule

/* File: dv/cit_crt_monitor.sv */
`timescale 1ns/1ps

// Monitor and display memory on the far side of the controller
module cit_crt_monitor (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire cit_pkg::cit_video_t video,
    input  wire logic                penReq,
    output      logic                lightPenIn,
    output      logic [7:0]          hsWidth,
    output      logic [7:0]          hsPeriod,
    output      logic [9:0]          vsWidth,
    output      logic [7:0]          vsDist,
    output      logic [7:0]          deDist,
    output      logic [7:0]          curDist,
    output      logic [13:0]         seenMa,
    output      logic [7:0]          updCount,
    output      logic [7:0]          vsCount,
    output      logic                raPar
);
    cit_pkg::cit_video_t prev;    // Pins one tick ago
    logic [7:0]          sinceHs; // Ticks since the last hsync rise
    logic [7:0]          hsRun;   // Length of the running hsync
    logic [9:0]          vsRun;   // Length of the running vsync
    logic [1:0]          penCnt;  // Pen hold time left
    logic                firstDe; // Next enable rise opens a field

    // Pen held three ticks, then back to its idle low level
    assign lightPenIn = (penCnt != 2'd0);

    // Edges only are timed, so the pipeline depth cancels out
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {prev, sinceHs, hsRun, vsRun, penCnt, firstDe} <= '0;
            {hsWidth, hsPeriod, vsWidth, vsDist, deDist} <= '0;
            {curDist, seenMa, updCount, vsCount, raPar} <= '0;
        end else begin
            prev    <= video;
            sinceHs <= sinceHs + 8'h01;
            hsRun   <= video.hsync ? hsRun + 8'h01 : 8'h00;
            vsRun   <= video.vsync ? vsRun + 10'h001 : 10'h000;
            penCnt  <= penReq ? 2'd3 : penCnt - {1'b0, penCnt != 2'd0};
            // Line start as the monitor sees it
            if (video.hsync && !prev.hsync) begin
                sinceHs  <= 8'h01;
                hsPeriod <= sinceHs;
            end
            if (prev.hsync && !video.hsync) hsWidth <= hsRun;
            if (prev.vsync && !video.vsync) vsWidth <= vsRun;
            // Field start: note where in the line it fell
            if (video.vsync && !prev.vsync) begin
                vsDist  <= sinceHs;
                vsCount <= vsCount + 8'h01;
                firstDe <= 1'b1;
            end
            // First shown line of a field tells its line parity
            if (video.de && !prev.de) begin
                deDist  <= sinceHs;
                firstDe <= 1'b0;
                if (firstDe) raPar <= video.ra[0];
            end
            if (video.cursor && !prev.cursor) begin
                curDist <= sinceHs;
                seenMa  <= video.ma;
            end
            // Memory takes the update address while strobed
            if (video.updStb) begin
                seenMa   <= video.ma;
                updCount <= updCount + 8'h01;
            end
        end
    end
endmodule

/* File: dv/cit_crt_timing_bench.sv */
`timescale 1ns/1ps

// Self-checking bench for the raster timing controller
module cit_crt_timing_bench;
    localparam int L = 20;              // Line length in ticks
    logic                mclk;
    logic                rst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                lightPenIn;
    logic                penReq;
    cit_pkg::cit_video_t video;
    logic [7:0]          hsWidth, hsPeriod, vsDist, deDist, curDist;
    logic [7:0]          updCount, vsCount, a, b, h, d;
    logic [9:0]          vsWidth;
    logic [13:0]         seenMa, u;
    logic                raPar, e, p;
    int                  failures, samplesChecked, seed, k;
    // Readable places and the raster set-up, index 0 upward
    logic [5:0] rdList [7] = '{6'h08, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12,
                               6'h13};
    logic [7:0] pVal [14] = '{8'h13, 8'h0a, 8'h0c, 8'h28, 8'h04, 8'h00,
        8'h03, 8'h03, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h00};

    cit_crt_timing u_cit_crt_timing (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lightPenIn(lightPenIn),
        .video(video));
    cit_crt_monitor u_cit_crt_monitor (
        .mclk(mclk), .rst(rst), .video(video), .penReq(penReq),
        .lightPenIn(lightPenIn), .hsWidth(hsWidth), .hsPeriod(hsPeriod),
        .vsWidth(vsWidth), .vsDist(vsDist), .deDist(deDist),
        .curDist(curDist), .seenMa(seenMa), .updCount(updCount),
        .vsCount(vsCount), .raPar(raPar));

    // Character clock, 40 ns period
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // Compare and count; an unknown never matches
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] adr,
                       input logic [7:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= {24'h000000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        d = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        apb(1'b1, {idx, 2'b00}, v);
    endtask

    task automatic rd(input logic [5:0] idx);
        apb(1'b0, {idx, 2'b00}, 8'h00);
    endtask

    // Let n fields pass; bounded so a dead raster cannot hang us
    task automatic waitVs(input int n);
        int w;
        logic [7:0] t;
        w = 0;
        t = vsCount + 8'(n);
        while (vsCount !== t && w < 8000) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 8000) failures++;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run is some thirteen thousand ticks; this is far past it
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        print_verdict();
    end

    initial begin
        {seed, failures, samplesChecked} = {32'hf7097139, 64'h0};
        {rst, psel, penable, pwrite, penReq} = 5'b10000;
        paddr  = 8'h00;
        pwdata = 32'h00000000;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Readable places come up zero without error
        foreach (rdList[i]) begin
            rd(rdList[i]);
            check("reset value", {7'h00, e, d}, 16'h0000);
        end
        // Unmapped and misaligned accesses are refused
        rd(6'h15);
        check("unmapped err", e, 1'b1);
        apb(1'b0, 8'h21, 8'h00);
        check("misaligned err", e, 1'b1);
        wr(cit_pkg::IDX_START_HIGH, 8'h15);
        rd(cit_pkg::IDX_START_HIGH);
        check("start high write only", d, 8'h00);
        wr(cit_pkg::IDX_PEN_HIGH, 8'h2a);
        rd(cit_pkg::IDX_PEN_HIGH);
        check("pen high read only", d, 8'h00);
        repeat (4) begin
            a = 8'($random(seed)) & 8'h3f;
            b = 8'($random(seed));
            wr(cit_pkg::IDX_MODE_CONTROL, a);
            wr(cit_pkg::IDX_CURSOR_LOW, b);
            rd(cit_pkg::IDX_MODE_CONTROL);
            check("mode read back", d, a);
            rd(cit_pkg::IDX_CURSOR_LOW);
            check("cursor low read back", d, b);
        end
        // Small raster: 20 ticks, 3 shown rows of 4 lines, 5 rows
        for (int i = 0; i < 14; i++) wr(6'(i), pVal[i]);
        // Random line lengths and widths, zero width meaning 16
        for (int i = 0; i < 3; i++) begin
            h = 8'd19 + (8'($random(seed)) & 8'h0f);
            a = (i == 0) ? 8'h00 : 8'($random(seed)) & 8'h0f;
            wr(cit_pkg::IDX_H_TOTAL, h);
            wr(cit_pkg::IDX_SYNC_WIDTH, 8'h20 | a);
            waitVs(2);
            check("line period", hsPeriod, h + 8'h01);
            check("hsync width", hsWidth, (a == 0) ? 8'd16 : a);
            check("vsync width", vsWidth, 10'd2 * (h + 10'd1));
        end
        wr(cit_pkg::IDX_H_TOTAL, 8'(L - 1));
        wr(cit_pkg::IDX_SYNC_WIDTH, 8'h28);
        // Every scan mode: vsync offset and first line parity
        for (int m = 0; m < 4; m++) begin
            wr(cit_pkg::IDX_MODE_CONTROL, 8'(m));
            waitVs(2);
            a = vsDist;
            p = raPar;
            waitVs(1);
            check("half line", (vsDist-a+L)%L, m[0] ? L/2 : 0);
            check("line parity", raPar ^ p, m == 3);
        end
        // Cursor at row 1 column 3, straight binary; all skew settings
        wr(cit_pkg::IDX_CURSOR_HIGH, 8'h00);
        wr(cit_pkg::IDX_CURSOR_LOW, 8'd13);
        for (int s = 0; s < 4; s++) begin
            wr(cit_pkg::IDX_MODE_CONTROL, 8'(s << 4));
            waitVs(2);
            if (s == 0) begin
                a = deDist;
                b = curDist;
                check("binary cursor addr", seenMa, 14'd13);
                check("cursor column", b - a, 8'd3);
            end
            check("enable skew", deDist, a + 8'(s & 1));
            check("cursor skew", curDist, b + 8'(s >> 1));
        end
        // Row and column format: high byte row, low byte column
        wr(cit_pkg::IDX_MODE_CONTROL, 8'h04);
        wr(cit_pkg::IDX_CURSOR_HIGH, 8'h01);
        wr(cit_pkg::IDX_CURSOR_LOW, 8'h03);
        waitVs(2);
        check("rowcol cursor addr", seenMa, 14'h0103);
        check("rowcol cursor column", curDist, b);
        // Pen strike sets the full flag; reading the capture clears it
        penReq <= 1'b1;
        @(posedge mclk);
        penReq <= 1'b0;
        k = 0;
        do begin
            rd(cit_pkg::IDX_STATUS);
            k++;
        end while (d[6] !== 1'b1 && k < 8);
        check("pen full set", d[6], 1'b1);
        rd(cit_pkg::IDX_PEN_LOW);
        rd(cit_pkg::IDX_STATUS);
        check("pen full cleared", d[6], 1'b0);
        // Shared addressing: touching the trigger place does nothing
        wr(cit_pkg::IDX_MODE_CONTROL, 8'h00);
        h = updCount;
        wr(cit_pkg::IDX_UPDATE_TRIG, 8'h00);
        waitVs(1);
        check("no strobe when shared", updCount, h);
        // Transparent: random update address goes out once, then steps
        u = 14'($random(seed));
        wr(cit_pkg::IDX_MODE_CONTROL, 8'h08);
        wr(cit_pkg::IDX_UPDATE_HIGH, {2'b00, u[13:8]});
        wr(cit_pkg::IDX_UPDATE_LOW, u[7:0]);
        rd(cit_pkg::IDX_UPDATE_TRIG);
        waitVs(1);
        check("one strobe", updCount, h + 8'h01);
        check("update address", seenMa, u);
        u = u + 14'h0001;
        rd(cit_pkg::IDX_UPDATE_LOW);
        a = d;
        rd(cit_pkg::IDX_UPDATE_HIGH);
        check("update step", {d[5:0], a}, u);
        rd(cit_pkg::IDX_STATUS);
        check("update ready", d[7], 1'b1);
        print_verdict();
    end
endmodule
